// *** host_irq_pkg.sv ***
// Purpose: Shared constants for the host interrupt event and mask block
// Assumes: 32-bit AHB-Lite register bus, word accesses only
// Notes: Offsets are byte addresses within the block's 256-byte window

package host_irq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;      // Register and bus data width
  localparam int OFS_W = 8;        // Decoded low address bits
  localparam int NUM_SRC = 7;      // Latched hardware event sources

  // ----------------------------------------------------------------
  // Register offsets (set alias, clear alias pairs)
  // ----------------------------------------------------------------
  localparam logic [OFS_W-1:0] OFS_EVENT_SET = 8'h00;
  localparam logic [OFS_W-1:0] OFS_EVENT_CLR = 8'h04;
  localparam logic [OFS_W-1:0] OFS_MASK_SET = 8'h08;
  localparam logic [OFS_W-1:0] OFS_MASK_CLR = 8'h0c;
  localparam logic [OFS_W-1:0] OFS_ISO_TX_EVT_SET = 8'h10;
  localparam logic [OFS_W-1:0] OFS_ISO_TX_EVT_CLR = 8'h14;
  localparam logic [OFS_W-1:0] OFS_ISO_TX_MSK_SET = 8'h18;
  localparam logic [OFS_W-1:0] OFS_ISO_TX_MSK_CLR = 8'h1c;
  localparam logic [OFS_W-1:0] OFS_ISO_RX_EVT_SET = 8'h20;
  localparam logic [OFS_W-1:0] OFS_ISO_RX_EVT_CLR = 8'h24;
  localparam logic [OFS_W-1:0] OFS_ISO_RX_MSK_SET = 8'h28;
  localparam logic [OFS_W-1:0] OFS_ISO_RX_MSK_CLR = 8'h2c;

  // ----------------------------------------------------------------
  // Event bit positions
  // ----------------------------------------------------------------
  localparam int BIT_ISO_TX_SUM = 6;  // Unlatched transmit summary
  localparam int BIT_ISO_RX_SUM = 7;  // Unlatched receive summary
  // Bit position of each latched source, index order of the source vector
  localparam int SRC_POS [NUM_SRC] = '{0, 1, 2, 3, 4, 5, 8};

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] LATCHED_BITS = 32'h0000013f; // Bits 0-5, 8
  localparam logic [DATA_W-1:0] MASK_BITS = 32'h000001ff;    // Bits 0-8
  localparam logic [DATA_W-1:0] ISO_BITS = 32'hffffffff;     // All contexts
  localparam logic [DATA_W-1:0] RST_WORD = 32'h00000000;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

endpackage

// *** host_interrupt_event_mask.sv ***
// Purpose: Interrupt event latch, mask gating and processor interrupt of a serial-bus host controller
// Assumes: Event sources come from logic on clk, so they are not synchronised
// Notes: Reads take one wait state so that hrdata comes from a flip-flop
//
// What this block does
// - DMA and device events both raise interrupt events
// - Set and clear aliases; zero bits change nothing
// - Interrupt high while event AND mask nonzero
// - Clear write drops interrupt unless new event
// - Bit set on source rising edge or set write
// - Set alias reads raw, clear alias reads masked
// - Event contents after reset need not be defined
// - Four isochronous event/mask registers with aliases
// - Bit 0: request transmit final command done
// - Bit 1: response transmit final command done
// - Bit 2: receive request buffer completed
// - Bit 3: receive response buffer completed
// - Bit 4: receive request packet stored, status updated
// - Bit 5: receive response packet stored, status updated
// - Bit 6: OR of masked transmit isochronous events
// - Bit 7: OR of masked receive isochronous events
// - Bit 8: posted write host bus error
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.

`timescale 1ns/1ps

module host_interrupt_event_mask
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // DMA-class event sources, active high levels
  input wire logic requestTxDone,
  input wire logic responseTxDone,
  input wire logic rxRequestBufferDone,
  input wire logic rxResponseBufferDone,
  input wire logic rxRequestPacketDone,
  input wire logic rxResponsePacketDone,
  // Device-class event source
  input wire logic postedWriteFault,
  // Isochronous per-context event sources
  input wire logic [31:0] isoTxSource,
  input wire logic [31:0] isoRxSource,
  // Processor interrupt
  output logic hostIrq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [31:0] interruptEventReg;     // Latched event bits
    logic [31:0] interruptEnableMask;   // Event enable mask
    logic [31:0] isoTxEventReg;         // Transmit context events
    logic [31:0] isoTxMaskReg;          // Transmit context mask
    logic [31:0] isoRxEventReg;         // Receive context events
    logic [31:0] isoRxMaskReg;          // Receive context mask
    logic [host_irq_pkg::NUM_SRC-1:0] srcPrev; // Last source levels
    logic [31:0] isoTxPrev;             // Last transmit source levels
    logic [31:0] isoRxPrev;             // Last receive source levels
    logic pendWr;                       // Write data phase this cycle
    logic pendRd;                       // Read data phase in progress
    logic rdValid;                      // Read data captured
    logic inMap;                        // Address inside the window
    logic [host_irq_pkg::OFS_W-1:0] ofs; // Captured word offset
    logic [31:0] rdata;                 // Read data register
  } state_t;

  state_t st_ff;   // Registered state
  state_t nxt_st;  // Next state

  logic [host_irq_pkg::NUM_SRC-1:0] srcVec;  // Sources in position order
  logic [host_irq_pkg::NUM_SRC-1:0] srcRise; // Rising edges this cycle
  logic [31:0] srcEdgeBits;                  // Edges placed at bit positions
  logic [31:0] isoTxRise;                    // Transmit context edges
  logic [31:0] isoRxRise;                    // Receive context edges
  logic isoTxSum;                            // Masked transmit summary
  logic isoRxSum;                            // Masked receive summary
  logic [31:0] eventView;                    // Event register as software sees it
  logic accept;                              // Address phase taken

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Alias update; set wins over clear so an event in the clear cycle is kept
  function automatic logic [31:0] aliasUpd(input logic [31:0] cur, input logic [31:0] setBits,
                                           input logic [31:0] clrBits, input logic [31:0] writable);
    aliasUpd = ((cur & ~clrBits) | setBits) & writable;
  endfunction

  // Write strobe for one offset, zero when another register is addressed
  function automatic logic [31:0] wrBits(input logic en, input logic hit, input logic [7:0] ofs,
                                         input logic [7:0] target, input logic [31:0] data);
    wrBits = (en && hit && (ofs == target)) ? data : host_irq_pkg::RST_WORD;
  endfunction

  // ----------------------------------------------------------------
  // Event sources and edge detection
  // ----------------------------------------------------------------
  // DMA completions and the device fault share one edge detector
  assign srcVec = {postedWriteFault, rxResponsePacketDone, rxRequestPacketDone,
                   rxResponseBufferDone, rxRequestBufferDone, responseTxDone, requestTxDone};
  assign srcRise = srcVec & ~st_ff.srcPrev;
  assign isoTxRise = isoTxSource & ~st_ff.isoTxPrev;
  assign isoRxRise = isoRxSource & ~st_ff.isoRxPrev;

  // Scatter each source edge onto its event bit
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_bits
      logic hitBit;
      always_comb
      begin
        hitBit = 1'b0;
        for (int k = 0; k < host_irq_pkg::NUM_SRC; k++)
        begin
          // Sources at bits 0-5 and 8
          if (host_irq_pkg::SRC_POS[k] == gi)
          begin
            hitBit = hitBit | srcRise[k];
          end
        end
      end
      assign srcEdgeBits[gi] = hitBit;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Summaries and interrupt output
  // ----------------------------------------------------------------
  // Unlatched summaries follow the isochronous registers directly
  assign isoTxSum = |(st_ff.isoTxEventReg & st_ff.isoTxMaskReg);
  assign isoRxSum = |(st_ff.isoRxEventReg & st_ff.isoRxMaskReg);

  // Reserved bits are forced low by the latched layout
  always_comb
  begin
    eventView = st_ff.interruptEventReg & host_irq_pkg::LATCHED_BITS;
    eventView[host_irq_pkg::BIT_ISO_TX_SUM] = isoTxSum;
    eventView[host_irq_pkg::BIT_ISO_RX_SUM] = isoRxSum;
  end

  // Level interrupt; it falls as soon as the clear write lands
  assign hostIrq = |(eventView & st_ff.interruptEnableMask);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Only the first cycle of a read data phase stalls
  assign hreadyout = ~(st_ff.pendRd & ~st_ff.rdValid);
  assign hresp = host_irq_pkg::HRESP_OKAY;
  assign hrdata = st_ff.rdata;
  // Singles only; SEQ is treated like NONSEQ since bursts are not issued
  assign accept = hsel & htrans[1] & hready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] evSet;
    logic [31:0] evClr;
    logic [31:0] mkSet;
    logic [31:0] mkClr;
    logic [31:0] txSet;
    logic [31:0] txClr;
    logic [31:0] txMSet;
    logic [31:0] txMClr;
    logic [31:0] rxSet;
    logic [31:0] rxClr;
    logic [31:0] rxMSet;
    logic [31:0] rxMClr;
    nxt_st = st_ff;
    // Write strobes of the data phase
    evSet = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_EVENT_SET, hwdata);
    evClr = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_EVENT_CLR, hwdata);
    mkSet = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_MASK_SET, hwdata);
    mkClr = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_MASK_CLR, hwdata);
    txSet = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_ISO_TX_EVT_SET, hwdata);
    txClr = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_ISO_TX_EVT_CLR, hwdata);
    txMSet = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_ISO_TX_MSK_SET, hwdata);
    txMClr = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_ISO_TX_MSK_CLR, hwdata);
    rxSet = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_ISO_RX_EVT_SET, hwdata);
    rxClr = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_ISO_RX_EVT_CLR, hwdata);
    rxMSet = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_ISO_RX_MSK_SET, hwdata);
    rxMClr = wrBits(st_ff.pendWr, st_ff.inMap, st_ff.ofs, host_irq_pkg::OFS_ISO_RX_MSK_CLR, hwdata);

    // Main event register: hardware edges or software set
    nxt_st.interruptEventReg = aliasUpd(st_ff.interruptEventReg, evSet | srcEdgeBits, evClr,
                                        host_irq_pkg::LATCHED_BITS);
    nxt_st.interruptEnableMask = aliasUpd(st_ff.interruptEnableMask, mkSet, mkClr,
                                          host_irq_pkg::MASK_BITS);
    // Isochronous context registers
    nxt_st.isoTxEventReg = aliasUpd(st_ff.isoTxEventReg, txSet | isoTxRise, txClr, host_irq_pkg::ISO_BITS);
    nxt_st.isoTxMaskReg = aliasUpd(st_ff.isoTxMaskReg, txMSet, txMClr, host_irq_pkg::ISO_BITS);
    nxt_st.isoRxEventReg = aliasUpd(st_ff.isoRxEventReg, rxSet | isoRxRise, rxClr, host_irq_pkg::ISO_BITS);
    nxt_st.isoRxMaskReg = aliasUpd(st_ff.isoRxMaskReg, rxMSet, rxMClr, host_irq_pkg::ISO_BITS);
    nxt_st.srcPrev = srcVec;
    nxt_st.isoTxPrev = isoTxSource;
    nxt_st.isoRxPrev = isoRxSource;

    // Data phase bookkeeping
    nxt_st.pendWr = 1'b0;
    if (st_ff.pendRd && !st_ff.rdValid)
    begin
      // Capture read data; unmapped offsets read zero
      nxt_st.rdValid = 1'b1;
      nxt_st.rdata = host_irq_pkg::RST_WORD;
      if (st_ff.inMap)
      begin
        case (st_ff.ofs)
          host_irq_pkg::OFS_EVENT_SET: nxt_st.rdata = eventView;
          host_irq_pkg::OFS_EVENT_CLR: nxt_st.rdata = eventView & st_ff.interruptEnableMask;
          host_irq_pkg::OFS_MASK_SET,
          host_irq_pkg::OFS_MASK_CLR: nxt_st.rdata = st_ff.interruptEnableMask;
          host_irq_pkg::OFS_ISO_TX_EVT_SET: nxt_st.rdata = st_ff.isoTxEventReg;
          host_irq_pkg::OFS_ISO_TX_EVT_CLR: nxt_st.rdata = st_ff.isoTxEventReg & st_ff.isoTxMaskReg;
          host_irq_pkg::OFS_ISO_TX_MSK_SET,
          host_irq_pkg::OFS_ISO_TX_MSK_CLR: nxt_st.rdata = st_ff.isoTxMaskReg;
          host_irq_pkg::OFS_ISO_RX_EVT_SET: nxt_st.rdata = st_ff.isoRxEventReg;
          host_irq_pkg::OFS_ISO_RX_EVT_CLR: nxt_st.rdata = st_ff.isoRxEventReg & st_ff.isoRxMaskReg;
          host_irq_pkg::OFS_ISO_RX_MSK_SET,
          host_irq_pkg::OFS_ISO_RX_MSK_CLR: nxt_st.rdata = st_ff.isoRxMaskReg;
          default: nxt_st.rdata = host_irq_pkg::RST_WORD;
        endcase
      end
    end
    else if (st_ff.pendRd)
    begin
      // Read data presented this cycle with hreadyout high
      nxt_st.pendRd = 1'b0;
      nxt_st.rdValid = 1'b0;
    end

    // New address phase overrides the finished one
    if (accept)
    begin
      nxt_st.pendWr = hwrite;
      nxt_st.pendRd = ~hwrite;
      nxt_st.rdValid = 1'b0;
      nxt_st.inMap = (haddr[31:host_irq_pkg::OFS_W] == '0);
      nxt_st.ofs = {haddr[host_irq_pkg::OFS_W-1:2], 2'h0};
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Events clear at reset for a defined start, though software may not rely on it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Write data phase to one offset
  sequence s_wr(logic [7:0] target);
    ce && st_ff.pendWr && st_ff.inMap && st_ff.ofs == target;
  endsequence

  // First cycle of a read data phase to one offset
  sequence s_rdCap(logic [7:0] target);
    ce && st_ff.pendRd && !st_ff.rdValid && st_ff.inMap && st_ff.ofs == target;
  endsequence

  // Rebuilt from the stored registers, not from the design's own view
  property p_irqLevel;
    hostIrq == (|(st_ff.interruptEventReg & st_ff.interruptEnableMask & host_irq_pkg::LATCHED_BITS)
      || (st_ff.interruptEnableMask[host_irq_pkg::BIT_ISO_TX_SUM] && |(st_ff.isoTxEventReg & st_ff.isoTxMaskReg))
      || (st_ff.interruptEnableMask[host_irq_pkg::BIT_ISO_RX_SUM] && |(st_ff.isoRxEventReg & st_ff.isoRxMaskReg)));
  endproperty
  a_irqLevel: assert property (p_irqLevel) else $error("interrupt does not follow event and mask");

  property p_srcEdge;
    ce && srcRise[0] |=> st_ff.interruptEventReg[host_irq_pkg::SRC_POS[0]];
  endproperty
  a_srcEdge: assert property (p_srcEdge) else $error("source edge did not set event bit");

  property p_faultEdge;
    ce && srcRise[6] |=> st_ff.interruptEventReg[host_irq_pkg::SRC_POS[6]];
  endproperty
  a_faultEdge: assert property (p_faultEdge) else $error("posted write fault not latched");

  property p_evSet;
    s_wr(host_irq_pkg::OFS_EVENT_SET) |=>
      ((st_ff.interruptEventReg & $past(hwdata) & host_irq_pkg::LATCHED_BITS)
       == ($past(hwdata) & host_irq_pkg::LATCHED_BITS));
  endproperty
  a_evSet: assert property (p_evSet) else $error("event set write lost");

  property p_evClr;
    s_wr(host_irq_pkg::OFS_EVENT_CLR) ##0 (srcEdgeBits == '0) |=>
      (st_ff.interruptEventReg & $past(hwdata)) == '0;
  endproperty
  a_evClr: assert property (p_evClr) else $error("event clear write did not clear");

  property p_clrSetWins;
    s_wr(host_irq_pkg::OFS_EVENT_CLR) ##0 srcRise[0] |=> st_ff.interruptEventReg[host_irq_pkg::SRC_POS[0]];
  endproperty
  a_clrSetWins: assert property (p_clrSetWins) else $error("event lost in its clear cycle");

  property p_mskSet;
    s_wr(host_irq_pkg::OFS_MASK_SET) |=>
      st_ff.interruptEnableMask == (($past(st_ff.interruptEnableMask) | $past(hwdata)) & host_irq_pkg::MASK_BITS);
  endproperty
  a_mskSet: assert property (p_mskSet) else $error("mask set write wrong");

  property p_isoTxClr;
    s_wr(host_irq_pkg::OFS_ISO_TX_EVT_CLR) ##0 (isoTxRise == '0) |=>
      st_ff.isoTxEventReg == ($past(st_ff.isoTxEventReg) & ~$past(hwdata));
  endproperty
  a_isoTxClr: assert property (p_isoTxClr) else $error("transmit context clear wrong");

  property p_rdRaw;
    s_rdCap(host_irq_pkg::OFS_EVENT_SET) |=> hreadyout && hrdata == $past(eventView);
  endproperty
  a_rdRaw: assert property (p_rdRaw) else $error("raw event read wrong");

  property p_rdMasked;
    s_rdCap(host_irq_pkg::OFS_EVENT_CLR) |=> hrdata == $past(eventView & st_ff.interruptEnableMask);
  endproperty
  a_rdMasked: assert property (p_rdMasked) else $error("masked event read wrong");

  property p_summaries;
    // Checked where software sees it: the raw read data
    s_rdCap(host_irq_pkg::OFS_EVENT_SET) |=>
      hrdata[host_irq_pkg::BIT_ISO_TX_SUM] == $past(|(st_ff.isoTxEventReg & st_ff.isoTxMaskReg))
      && hrdata[host_irq_pkg::BIT_ISO_RX_SUM] == $past(|(st_ff.isoRxEventReg & st_ff.isoRxMaskReg));
  endproperty
  a_summaries: assert property (p_summaries) else $error("isochronous summary bit wrong");

  property p_reserved;
    (st_ff.interruptEventReg & ~host_irq_pkg::LATCHED_BITS) == '0
    && (st_ff.interruptEnableMask & ~host_irq_pkg::MASK_BITS) == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved event bit set");

endmodule

// *** irq_sink.sv ***
// Purpose: Processor interrupt input that stands beside the block
// Assumes: Level interrupt, active high, same clock as the block
// Notes: Counts requests so the bench can see the line really toggled

`timescale 1ns/1ps

module irq_sink
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Interrupt line from the block
  input wire logic hostIrq,
  // Requests seen so far
  output int irqEdges
);
  logic prevIrq; // Last sampled level

  // Count each new request; a level held high counts once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prevIrq <= 1'b0;
      irqEdges <= 0;
    end
    else
    begin
      prevIrq <= hostIrq;
      if (hostIrq === 1'b1 && prevIrq !== 1'b1)
        irqEdges <= irqEdges + 1;
    end
  end
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the interrupt event and mask block
// Assumes: Word accesses only, ce held high, hready fed from hreadyout
// Notes: Event contents after reset are cleared first, never trusted

`timescale 1ns/1ps

module tb;
  // ------------------------------------------------------------
  // Signals and bench model
  // ------------------------------------------------------------
  logic clk, rst_n, hwrite, hreadyout, hresp, hostIrq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, isoTx, isoRx, rdv, d, m;
  logic [6:0] src;
  logic [31:0] evt, msk; // Model of main event and mask
  logic [31:0] iev [2]; // Model of iso events, tx then rx
  logic [31:0] imk [2]; // Model of iso masks
  int mismatches, n_tests, seed, irqEdges;

  host_interrupt_event_mask DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .requestTxDone(src[0]),
    .responseTxDone(src[1]), .rxRequestBufferDone(src[2]), .rxResponseBufferDone(src[3]),
    .rxRequestPacketDone(src[4]), .rxResponsePacketDone(src[5]), .postedWriteFault(src[6]),
    .isoTxSource(isoTx), .isoRxSource(isoRx), .hostIrq(hostIrq));
  irq_sink sink (.clk(clk), .rst_n(rst_n), .hostIrq(hostIrq), .irqEdges(irqEdges));

  // Free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  // Event view: latched bits plus the two unlatched summaries
  function automatic logic [31:0] view();
    view = (evt & host_irq_pkg::LATCHED_BITS) | {24'h0, |(iev[1] & imk[1]), |(iev[0] & imk[0]), 6'h0};
  endfunction

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait for an edge that samples hready high
  task automatic waitReady;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        mismatches++;
        conclude;
      end
      @(posedge clk);
    end
  endtask

  // One single AHB-Lite word transfer, entered just after a rising edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] q);
    htrans <= host_irq_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    waitReady;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady;
    q = hrdata;
    check("hresp", {31'h0, hresp}, {31'h0, host_irq_pkg::HRESP_OKAY});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(a, 1'b1, wd, q);
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, rdv);
    check(nm, rdv, exp);
  endtask

  // Interrupt level once the last write has landed
  task automatic irqChk;
    @(negedge clk);
    check("hostIrq", {31'h0, hostIrq}, {31'h0, |(view() & msk)});
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 32'h42d1;
    rst_n = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    src = 7'h0;
    isoTx = 32'h0;
    isoRx = 32'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Clear every register; reset contents are not relied on
    for (int a = 4; a < 48; a += 8)
      wr(a, 32'hffffffff);
    evt = 0; msk = 0; iev = '{0, 0}; imk = '{0, 0};
    rchk("events", 32'h00, 32'h0);
    // Random set and clear traffic, then the service routine
    for (int i = 0; i < 10; i++)
    begin
      d = $random(seed);
      m = $random(seed);
      wr(host_irq_pkg::OFS_EVENT_SET, d);
      evt = evt | d;
      wr(host_irq_pkg::OFS_MASK_SET, m);
      msk = msk | (m & host_irq_pkg::MASK_BITS);
      wr(host_irq_pkg::OFS_MASK_CLR, d);
      msk = msk & ~d;
      rchk("rawEvents", host_irq_pkg::OFS_EVENT_SET, view());
      rchk("maskedEvents", host_irq_pkg::OFS_EVENT_CLR, view() & msk);
      rchk("mask", host_irq_pkg::OFS_MASK_CLR, msk);
      irqChk;
      bus(host_irq_pkg::OFS_EVENT_CLR, 1'b0, 32'h0, rdv);
      wr(host_irq_pkg::OFS_EVENT_CLR, rdv);
      evt = evt & ~rdv;
      irqChk;
    end
    // Each hardware source: edge sets the bit, a held level does not
    wr(host_irq_pkg::OFS_EVENT_CLR, 32'hffffffff);
    evt = 0;
    wr(host_irq_pkg::OFS_MASK_SET, 32'hffffffff);
    msk = host_irq_pkg::MASK_BITS;
    for (int i = 0; i < host_irq_pkg::NUM_SRC; i++)
    begin
      src[i] <= 1'b1;
      evt[host_irq_pkg::SRC_POS[i]] = 1'b1;
      repeat (2) @(posedge clk);
      rchk("sourceEvent", host_irq_pkg::OFS_EVENT_SET, view());
      irqChk;
      wr(host_irq_pkg::OFS_EVENT_CLR, 32'hffffffff);
      evt = 0;
      rchk("heldSource", host_irq_pkg::OFS_EVENT_SET, view());
      irqChk;
      src[i] <= 1'b0;
      @(posedge clk);
    end
    // Corner: a source edge lands in the clear write's own data phase; the set must win
    fork
      wr(host_irq_pkg::OFS_EVENT_CLR, 32'hffffffff);
      begin
        @(posedge clk);
        src[0] <= 1'b1;
      end
    join
    evt = 32'h1;
    rchk("setWins", host_irq_pkg::OFS_EVENT_SET, view());
    src[0] <= 1'b0;
    // Isochronous contexts and their summary bits
    for (int j = 0; j < 2; j++)
    begin
      d = $random(seed) | 32'h80000001;
      if (j == 0)
        isoTx <= d;
      else
        isoRx <= d;
      iev[j] = d;
      m = $random(seed) | 32'h00000001;
      repeat (2) @(posedge clk);
      wr(32'h18 + 32'h10 * j, m);
      imk[j] = m;
      rchk("isoEvent", 32'h10 + 32'h10 * j, iev[j]);
      rchk("isoMasked", 32'h14 + 32'h10 * j, iev[j] & imk[j]);
      rchk("summarySet", host_irq_pkg::OFS_EVENT_SET, view());
      irqChk;
      wr(32'h1c + 32'h10 * j, 32'hffffffff);
      imk[j] = 0;
      wr(host_irq_pkg::OFS_EVENT_CLR, 32'h000000c0);
      rchk("summaryOff", host_irq_pkg::OFS_EVENT_SET, view());
      irqChk;
    end
    // Unmapped place: reads zero, writes land nowhere
    wr(32'h00000100, 32'hffffffff);
    rchk("unmapped", 32'h00000100, 32'h0);
    rchk("afterUnmapped", host_irq_pkg::OFS_EVENT_SET, view());
    check("irqRequests", {31'h0, irqEdges > 0}, 32'h1);
    conclude;
  end
endmodule
